/* logic/rffe_output_expander.sv */
// Eight-output expander core behind decoded serial-bus register commands.
`timescale 1ns/100ps
`default_nettype none
module rffe_output_expander #(
  parameter int unsigned NUM_OUTPUTS = rffe_expander_pkg::NUM_OUTPUTS
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic bus_supply_reset_input_i,
  input wire logic addr_select_i,
  input wire logic config_select_i,
  input wire logic [3:0] cmd_usid_i,
  input wire logic [4:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rd_data_o,
  output logic [3:0] usid_o,
  output logic mode_o,
  output logic [NUM_OUTPUTS-1:0] output_pin_o,
  output logic [NUM_OUTPUTS-1:0] output_pin_oe_o,
  output logic [NUM_OUTPUTS-1:0] pull_up_en_o,
  output logic [NUM_OUTPUTS-1:0] pull_down_en_o
);
  // Register select shared by the write and read decoders.
  function automatic logic reg_sel(input logic [4:0] addr, input logic [4:0] offs);
    reg_sel = (addr == offs);
  endfunction : reg_sel

  logic adr_sync;
  logic cfg_sync;
  logic supply_ok_sync;
  logic soft_reset_reg;
  logic any_reset;
  rffe_expander_pkg::init_mode_t mode_reg;
  rffe_expander_pkg::init_state_t state_reg;
  rffe_expander_pkg::init_state_t state_next;
  logic [3:0] usid_reg;
  logic [7:0] value_reg;
  logic [7:0] value_next;
  logic [7:0] mask_reg;
  logic [7:0] pull_dir_reg;
  logic [7:0] pull_en_reg;
  logic [7:0] high_cfg_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_mux;
  logic [7:0] status_word;
  logic [7:0] mask_default;
  logic [3:0] usid_default;
  logic usid_hit;
  logic wr_hit;
  logic rd_hit;
  logic wr_value;
  logic wr_mask;
  logic wr_pull_dir;
  logic wr_pull_en;
  logic wr_high_cfg;
  logic wr_soft;
  logic cfg_writable;
  logic is_auto;

  // The straps are tied in a real board but still pass a synchroniser before use.
  level_sync #(
    .WIDTH(2),
    .STAGES(rffe_expander_pkg::SYNC_STAGES)
  ) u_strap_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({addr_select_i, config_select_i}),
    .sync_o({adr_sync, cfg_sync})
  );

  // One extra stage keeps the core in reset until the strap synchroniser holds the pin level.
  level_sync #(
    .WIDTH(1),
    .STAGES(rffe_expander_pkg::SUPPLY_SYNC_STAGES)
  ) u_supply_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(bus_supply_reset_input_i),
    .sync_o(supply_ok_sync)
  );

  // All three reset sources merge into one synchronous core reset.
  assign any_reset = ~rst_n_i | ~supply_ok_sync | soft_reset_reg;

  // Identity and mask defaults come straight from the synchronised straps.
  assign usid_default = adr_sync ? rffe_expander_pkg::USID_ADR_HIGH
                                 : rffe_expander_pkg::USID_ADR_LOW;
  assign mask_default = cfg_sync ? rffe_expander_pkg::MASK_RST_GENERAL
                                 : rffe_expander_pkg::MASK_RST_AUTO;

  // Writes take our identity or broadcast; reads need our own identity.
  assign usid_hit = (cmd_usid_i == usid_reg);
  assign wr_hit = wr_en_i & ~any_reset &
                  (usid_hit | (cmd_usid_i == rffe_expander_pkg::USID_BROADCAST));
  assign rd_hit = rd_en_i & ~any_reset & usid_hit;

  // Write decode per register.
  assign wr_value = wr_hit & reg_sel(addr_i, rffe_expander_pkg::VALUE_OFFS);
  assign wr_mask = wr_hit & reg_sel(addr_i, rffe_expander_pkg::MASK_OFFS);
  assign wr_pull_dir = wr_hit & reg_sel(addr_i, rffe_expander_pkg::PULL_DIR_OFFS);
  assign wr_pull_en = wr_hit & reg_sel(addr_i, rffe_expander_pkg::PULL_EN_OFFS);
  assign wr_high_cfg = wr_hit & reg_sel(addr_i, rffe_expander_pkg::HIGH_CFG_OFFS);
  assign wr_soft = wr_hit & reg_sel(addr_i, rffe_expander_pkg::SOFT_RESET_OFFS) &
                   wr_data_i[rffe_expander_pkg::SOFT_RESET_BIT];

  // Pull and high configuration writes are ignored in automatic mode.
  assign is_auto = (mode_reg == rffe_expander_pkg::automatic_init_mode);
  assign cfg_writable = ~is_auto;

  // Masked bits keep their value; the first general-mode value write forces every output low.
  always_comb begin
    value_next = value_reg;
    state_next = state_reg;
    if (wr_value) begin
      state_next = rffe_expander_pkg::outputs_active;
      if (!is_auto && state_reg == rffe_expander_pkg::outputs_unconfigured) begin
        value_next = rffe_expander_pkg::VALUE_RST;
      end else begin
        value_next = (value_reg & mask_reg) | (wr_data_i & ~mask_reg);
      end
    end
  end

  // Mode, identity and defaults are reloaded on every reset source, so a soft reset
  // also re-reads the strap; this costs nothing because the straps are static.
  always_ff @(posedge ref_clk_i) begin
    if (any_reset) begin
      mode_reg <= rffe_expander_pkg::init_mode_t'(cfg_sync);
      usid_reg <= usid_default;
      state_reg <= rffe_expander_pkg::outputs_unconfigured;
      value_reg <= rffe_expander_pkg::VALUE_RST;
      mask_reg <= mask_default;
    end else begin
      state_reg <= state_next;
      value_reg <= value_next;
      if (wr_mask) begin
        mask_reg <= wr_data_i;
      end
    end
  end

  // Pull and drive configuration; automatic mode drops the pulls on a value write.
  always_ff @(posedge ref_clk_i) begin
    if (any_reset) begin
      pull_dir_reg <= rffe_expander_pkg::PULL_DIR_RST;
      pull_en_reg <= rffe_expander_pkg::PULL_EN_RST;
      high_cfg_reg <= rffe_expander_pkg::HIGH_CFG_RST;
    end else begin
      if (wr_value && is_auto) begin
        pull_en_reg <= rffe_expander_pkg::PULL_EN_OFF;
      end else if (wr_pull_en && cfg_writable) begin
        pull_en_reg <= wr_data_i;
      end
      if (wr_pull_dir && cfg_writable) begin
        pull_dir_reg <= wr_data_i;
      end
      if (wr_high_cfg && cfg_writable) begin
        high_cfg_reg <= wr_data_i;
      end
    end
  end

  // The software reset is a one-cycle pulse; only the hard sources clear it early.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || !supply_ok_sync) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_soft;
    end
  end

  // Read selection; unmapped offsets read as zero.
  assign status_word = {usid_reg, 2'b00, (state_reg == rffe_expander_pkg::outputs_active),
                        mode_reg};
  assign rd_mux =
    reg_sel(addr_i, rffe_expander_pkg::VALUE_OFFS) ? value_reg :
    reg_sel(addr_i, rffe_expander_pkg::MASK_OFFS) ? mask_reg :
    reg_sel(addr_i, rffe_expander_pkg::PULL_DIR_OFFS) ? pull_dir_reg :
    reg_sel(addr_i, rffe_expander_pkg::PULL_EN_OFFS) ? pull_en_reg :
    reg_sel(addr_i, rffe_expander_pkg::HIGH_CFG_OFFS) ? high_cfg_reg :
    reg_sel(addr_i, rffe_expander_pkg::STATUS_OFFS) ? status_word :
    rffe_expander_pkg::READ_IDLE;

  // Read data stands only in the cycle after the strobe and is zero otherwise.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_data_reg <= rffe_expander_pkg::READ_IDLE;
    end else begin
      rd_data_reg <= rd_hit ? rd_mux : rffe_expander_pkg::READ_IDLE;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign usid_o = usid_reg;
  assign mode_o = mode_reg;

  // One registered cell per output; pins follow the registers one cycle later.
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_pin
    output_pin_cell u_cell (
      .ref_clk_i(ref_clk_i),
      .cell_reset_i(any_reset),
      .active_i(state_reg == rffe_expander_pkg::outputs_active),
      .value_i(value_reg[g]),
      .high_cfg_i(high_cfg_reg[g]),
      .pull_en_i(pull_en_reg[g]),
      .pull_dir_i(pull_dir_reg[g]),
      .pin_o(output_pin_o[g]),
      .pin_oe_o(output_pin_oe_o[g]),
      .pull_up_o(pull_up_en_o[g]),
      .pull_down_o(pull_down_en_o[g])
    );
  end

  // Checks on the block's own behaviour.
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_quiet2;
    !any_reset ##1 !any_reset;
  endsequence
  sequence s_auto_value_write;
    wr_value && is_auto && !any_reset;
  endsequence
  sequence s_general_first_write;
    wr_value && !is_auto && !any_reset &&
    state_reg == rffe_expander_pkg::outputs_unconfigured;
  endsequence
  sequence s_soft_command;
    wr_soft && !any_reset;
  endsequence

  AST_USID_FROM_PIN: assert property (
    !any_reset ##1 !any_reset |-> usid_o == (adr_sync ? 4'h9 : 4'h1))
    else $error("Slave identity does not match the address select pin.");

  AST_RESET_DEFAULTS: assert property (
    any_reset |=> output_pin_oe_o == 8'h00 && pull_down_en_o == 8'hff &&
                  pull_up_en_o == 8'h00 && mask_reg == ($past(cfg_sync) ? 8'hff : 8'h00))
    else $error("Outputs did not return to floating with pull-down after reset.");

  AST_MODE_FROM_PIN: assert property (
    any_reset ##1 !any_reset |-> mode_o == $past(cfg_sync))
    else $error("Mode was not taken from the configuration pin at reset.");

  AST_AUTO_PULL_OFF: assert property (
    s_auto_value_write ##1 s_quiet2 |-> pull_down_en_o == 8'h00 && pull_up_en_o == 8'h00)
    else $error("Automatic mode value write left a pull enabled.");

  AST_AUTO_DRIVE: assert property (
    s_auto_value_write ##1 s_quiet2 |-> output_pin_oe_o == 8'hff &&
      output_pin_o == $past(value_reg, 1))
    else $error("Automatic mode value write did not drive every output.");

  AST_MASK_HOLDS: assert property (
    wr_value && !any_reset && state_reg == rffe_expander_pkg::outputs_active
    |=> (value_reg & $past(mask_reg)) == ($past(value_reg) & $past(mask_reg)) &&
        (value_reg & ~$past(mask_reg)) == ($past(wr_data_i) & ~$past(mask_reg)))
    else $error("Masked output bits changed on a value write.");

  AST_AUTO_IGNORES_CFG: assert property (
    is_auto && !any_reset && !wr_value |=> $stable(pull_en_reg) &&
      $stable(pull_dir_reg) && $stable(high_cfg_reg))
    else $error("Automatic mode accepted a pull or high configuration write.");

  AST_GENERAL_FIRST_LOW: assert property (
    s_general_first_write ##1 s_quiet2 |-> output_pin_oe_o == 8'hff &&
      output_pin_o == 8'h00 && pull_down_en_o == 8'hff)
    else $error("First general mode write did not drive all outputs low with pull-down.");

  AST_SOFT_RESET: assert property (
    s_soft_command |=> soft_reset_reg ##1 (!soft_reset_reg &&
      state_reg == rffe_expander_pkg::outputs_unconfigured &&
      value_reg == 8'h00 && pull_en_reg == 8'hff && high_cfg_reg == 8'hff))
    else $error("Software reset did not restore the defaults.");

  AST_DRIVE_SHAPE: assert property (
    s_quiet2 ##1 !any_reset |-> output_pin_oe_o == ($past(state_reg) ==
      rffe_expander_pkg::outputs_active ? (~$past(value_reg) | $past(high_cfg_reg)) : 8'h00))
    else $error("Output drive enable does not follow value and high configuration.");

  AST_PULLS_EXCLUSIVE: assert property (
    (pull_up_en_o & pull_down_en_o) == 8'h00)
    else $error("Pull-up and pull-down are both on for one output.");

  AST_READ_ONE_CYCLE: assert property (
    !rd_hit |=> rd_data_o == 8'h00)
    else $error("Read data stood outside the cycle after a read.");

  // The first two checks compare pins with registers; the register-level checks after them catch a broken decode at once,
  // where the pin checks above would only see its effect two cycles later and behind the drive logic.
  AST_PIN_LEVEL: assert property (
    s_quiet2 |-> output_pin_o == $past(value_reg))
    else $error("Output level does not follow the value register.");

  AST_PULLS_FOLLOW: assert property (
    s_quiet2 |-> pull_up_en_o == ($past(pull_en_reg) & $past(pull_dir_reg)) &&
      pull_down_en_o == ($past(pull_en_reg) & ~$past(pull_dir_reg)))
    else $error("Pull enables do not follow the pull configuration.");

  AST_GENERAL_DIR_TAKEN: assert property (
    wr_pull_dir && !is_auto |=> pull_dir_reg == $past(wr_data_i))
    else $error("General mode pull direction write was not taken.");

  AST_GENERAL_HIGH_TAKEN: assert property (
    wr_high_cfg && !is_auto |=> high_cfg_reg == $past(wr_data_i))
    else $error("General mode high configuration write was not taken.");

  AST_AUTO_CFG_FIXED: assert property (
    is_auto && !any_reset |-> high_cfg_reg == rffe_expander_pkg::HIGH_CFG_RST &&
      pull_dir_reg == rffe_expander_pkg::PULL_DIR_RST)
    else $error("Automatic mode pull direction or high configuration moved.");

  AST_STATE_STAYS: assert property (
    state_reg == rffe_expander_pkg::outputs_active && !any_reset |=>
      state_reg == rffe_expander_pkg::outputs_active)
    else $error("Outputs fell back to unconfigured without a reset.");

  AST_SOFT_PULSE: assert property (
    soft_reset_reg |=> !soft_reset_reg)
    else $error("Software reset lasted more than one cycle.");

  AST_READ_MASK: assert property (
    rd_hit && addr_i == rffe_expander_pkg::MASK_OFFS |=> rd_data_o == $past(mask_reg))
    else $error("Mask read did not return the mask register.");

  AST_FOREIGN_READ_ZERO: assert property (
    rd_en_i && cmd_usid_i != usid_reg |=> rd_data_o == rffe_expander_pkg::READ_IDLE)
    else $error("A read for another identity returned data.");
endmodule : rffe_output_expander
`default_nettype wire

/* logic/rffe_expander_pkg.sv */
// Constants, register map and state types for the serial-bus output expander.
`default_nettype none
package rffe_expander_pkg;
  localparam int unsigned NUM_OUTPUTS = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned USID_W = 4;
  // Slave identity taken from the address select pin, and the broadcast identity.
  localparam logic [3:0] USID_ADR_LOW = 4'h1;
  localparam logic [3:0] USID_ADR_HIGH = 4'h9;
  localparam logic [3:0] USID_BROADCAST = 4'h0;
  // Register offsets.
  localparam logic [4:0] VALUE_OFFS = 5'h00;
  localparam logic [4:0] MASK_OFFS = 5'h01;
  localparam logic [4:0] PULL_DIR_OFFS = 5'h02;
  localparam logic [4:0] PULL_EN_OFFS = 5'h03;
  localparam logic [4:0] HIGH_CFG_OFFS = 5'h04;
  localparam logic [4:0] STATUS_OFFS = 5'h05;
  localparam logic [4:0] SOFT_RESET_OFFS = 5'h06;
  // Reset values; a pull direction bit of zero selects the pull-down.
  localparam logic [7:0] VALUE_RST = 8'h00;
  localparam logic [7:0] MASK_RST_AUTO = 8'h00;
  localparam logic [7:0] MASK_RST_GENERAL = 8'hff;
  localparam logic [7:0] PULL_DIR_RST = 8'h00;
  localparam logic [7:0] PULL_EN_RST = 8'hff;
  localparam logic [7:0] HIGH_CFG_RST = 8'hff;
  localparam logic [7:0] PULL_EN_OFF = 8'h00;
  localparam logic [7:0] READ_IDLE = 8'h00;
  // Field positions.
  localparam int unsigned STATUS_MODE_BIT = 0;
  localparam int unsigned STATUS_STARTED_BIT = 1;
  localparam int unsigned SOFT_RESET_BIT = 0;
  // Synchroniser depths; the supply input takes one stage more than the straps.
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned SUPPLY_SYNC_STAGES = 3;
  typedef enum logic {
    automatic_init_mode = 1'b0,
    general_init_mode = 1'b1
  } init_mode_t;
  typedef enum logic {
    outputs_unconfigured = 1'b0,
    outputs_active = 1'b1
  } init_state_t;
endpackage : rffe_expander_pkg
`default_nettype wire

/* logic/level_sync.sv */
// Multi-stage synchroniser for levels that arrive from pins.
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned STAGES = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage_reg [STAGES];

  // Each flop but the last is read only by the next stage, so metastability settles before any logic sees it.
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_reg[i] <= '0;
      end
    end else begin
      stage_reg[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
    end
  end

  assign sync_o = stage_reg[STAGES-1];
endmodule : level_sync
`default_nettype wire

/* logic/output_pin_cell.sv */
// Registered drive and pull control for one expander output.
`timescale 1ns/100ps
`default_nettype none
module output_pin_cell (
  input wire logic ref_clk_i,
  input wire logic cell_reset_i,
  input wire logic active_i,
  input wire logic value_i,
  input wire logic high_cfg_i,
  input wire logic pull_en_i,
  input wire logic pull_dir_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic pull_up_o,
  output logic pull_down_o
);
  logic drive_next;

  // When active, a low is always driven; a high is driven or left floating by the high configuration.
  assign drive_next = active_i & (~value_i | high_cfg_i);

  // Reset state is high impedance with the weak pull-down on.
  always_ff @(posedge ref_clk_i) begin
    if (cell_reset_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_down_o <= 1'b1;
    end else begin
      pin_o <= value_i;
      pin_oe_o <= drive_next;
      pull_up_o <= pull_en_i & pull_dir_i;
      pull_down_o <= pull_en_i & ~pull_dir_i;
    end
  end
endmodule : output_pin_cell
`default_nettype wire

/* verif/rffe_host_model.sv */
// Host-side master model that issues decoded register commands to the expander.
`timescale 1ns/100ps
`default_nettype none
module rffe_host_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] rd_data_i,
  output var logic [3:0] cmd_usid_o,
  output var logic [4:0] addr_o,
  output var logic [7:0] wr_data_o,
  output var logic wr_en_o,
  output var logic rd_en_o
);
  // Idle lines start at rest so the core sees no request during reset.
  initial begin
    cmd_usid_o = 4'h0;
    addr_o = 5'h00;
    wr_data_o = 8'h00;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
  end

  // One-cycle write; released address and data lines are inverted so stale values never look valid.
  task automatic write_reg(input logic [3:0] id, input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    cmd_usid_o <= id;
    addr_o <= a;
    wr_data_o <= d;
    wr_en_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_en_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask : write_reg

  // One-cycle read; the data stand only in the following cycle.
  task automatic read_reg(input logic [3:0] id, input logic [4:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    cmd_usid_o <= id;
    addr_o <= a;
    rd_en_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_en_o <= 1'b0;
    addr_o <= ~a;
    @(negedge ref_clk_i);
    d = rd_data_i;
  endtask : read_reg

  // General mode set-up after the first value write: pulls and drive type, then mask and value.
  task automatic general_config(input logic [3:0] id, input logic [7:0] dir,
                                input logic [7:0] en, input logic [7:0] hc,
                                input logic [7:0] m, input logic [7:0] v);
    write_reg(id, rffe_expander_pkg::PULL_DIR_OFFS, dir);
    write_reg(id, rffe_expander_pkg::PULL_EN_OFFS, en);
    write_reg(id, rffe_expander_pkg::HIGH_CFG_OFFS, hc);
    write_reg(id, rffe_expander_pkg::MASK_OFFS, m);
    write_reg(id, rffe_expander_pkg::VALUE_OFFS, v);
  endtask : general_config
endmodule : rffe_host_model
`default_nettype wire

/* verif/rffe_output_expander_test.sv */
// Self-checking bench for the output expander core with a host model in front.
`timescale 1ns/100ps
`default_nettype none
module rffe_output_expander_test;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic supply = 1'b1;
  logic adr = 1'b0;
  logic cfg = 1'b0;
  logic [3:0] cmd_usid, usid;
  logic [4:0] addr;
  logic [7:0] wr_data, rd_data, pin, oe, pu, pd;
  logic wr_en, rd_en, mode;
  logic [7:0] v, m, d, e, h, r, val;
  int n_errors = 0;
  int num_checks = 0;
  int seed = 99;

  // Half period of 12.5 ns gives the 40 MHz reference.
  always #12.5 ref_clk_i = ~ref_clk_i;

  rffe_output_expander DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .bus_supply_reset_input_i(supply), .addr_select_i(adr), .config_select_i(cfg),
    .cmd_usid_i(cmd_usid), .addr_i(addr), .wr_data_i(wr_data), .wr_en_i(wr_en),
    .rd_en_i(rd_en), .rd_data_o(rd_data), .usid_o(usid), .mode_o(mode),
    .output_pin_o(pin), .output_pin_oe_o(oe), .pull_up_en_o(pu), .pull_down_en_o(pd));

  rffe_host_model host (.ref_clk_i(ref_clk_i), .rd_data_i(rd_data), .cmd_usid_o(cmd_usid),
    .addr_o(addr), .wr_data_o(wr_data), .wr_en_o(wr_en), .rd_en_o(rd_en));

  // Compares one byte-wide result.
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  // Compares the pin state; a level only matters where the driver is on.
  task automatic check_pins(input logic [7:0] ev, input logic [7:0] eoe,
                            input logic [7:0] eu, input logic [7:0] ed);
    num_checks++;
    if ((pin & oe) !== (ev & eoe) || oe !== eoe || pu !== eu || pd !== ed) begin
      n_errors++;
      $display("[FAIL] %0t pins %h oe %h pu %h pd %h", $time, pin, oe, pu, pd);
    end
  endtask : check_pins

  // Straps change with reset held; the core loads them after the release, while the supply synchroniser still holds it in reset.
  task automatic do_reset(input logic a, input logic c);
    @(posedge ref_clk_i);
    adr <= a;
    cfg <= c;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
  endtask : do_reset

  // Pins follow a write two cycles after its strobe.
  task automatic settle();
    repeat (2) @(negedge ref_clk_i);
  endtask : settle

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report

  // Watchdog: a hung sequence still reaches the verdict.
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    $display("[FAIL] %0t sequence did not finish", $time);
    final_report();
  end

  initial begin
    // Automatic mode with the address pin low.
    do_reset(1'b0, 1'b0);
    check_val({4'h0, usid}, 8'h01, "usid");
    check_val({7'h00, mode}, 8'h00, "mode");
    check_pins(8'h00, 8'h00, 8'h00, 8'hff);
    host.read_reg(4'h1, rffe_expander_pkg::MASK_OFFS, r);
    check_val(r, 8'h00, "mask auto");
    host.write_reg(4'h1, rffe_expander_pkg::PULL_EN_OFFS, 8'h00);
    host.write_reg(4'h1, rffe_expander_pkg::HIGH_CFG_OFFS, 8'h00);
    host.read_reg(4'h1, rffe_expander_pkg::PULL_EN_OFFS, r);
    check_val(r, 8'hff, "pull enable kept");
    val = 8'($random(seed));
    host.write_reg(4'h1, rffe_expander_pkg::VALUE_OFFS, val);
    settle();
    check_pins(val, 8'hff, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 8'hff : 8'($random(seed));
      v = 8'($random(seed));
      host.write_reg(4'h1, rffe_expander_pkg::MASK_OFFS, m);
      host.write_reg(4'h1, rffe_expander_pkg::VALUE_OFFS, v);
      val = (val & m) | (v & ~m);
      settle();
      check_pins(val, 8'hff, 8'h00, 8'h00);
    end
    host.read_reg(4'h1, rffe_expander_pkg::STATUS_OFFS, r);
    check_val(r, 8'h12, "status auto");
    host.write_reg(4'h9, rffe_expander_pkg::VALUE_OFFS, ~val);
    settle();
    check_pins(val, 8'hff, 8'h00, 8'h00);
    host.read_reg(4'h0, rffe_expander_pkg::STATUS_OFFS, r);
    check_val(r, 8'h00, "broadcast read");
    host.read_reg(4'h1, 5'h1f, r);
    check_val(r, 8'h00, "unmapped read");
    host.write_reg(4'h1, rffe_expander_pkg::SOFT_RESET_OFFS, 8'h01);
    repeat (3) @(negedge ref_clk_i);
    check_pins(8'h00, 8'h00, 8'h00, 8'hff);
    host.read_reg(4'h1, rffe_expander_pkg::VALUE_OFFS, r);
    check_val(r, 8'h00, "value after soft reset");
    $display("test automatic mode done");

    // General mode with the address pin high.
    do_reset(1'b1, 1'b1);
    check_val({4'h0, usid}, 8'h09, "usid");
    check_val({7'h00, mode}, 8'h01, "mode");
    check_pins(8'h00, 8'h00, 8'h00, 8'hff);
    host.read_reg(4'h9, rffe_expander_pkg::MASK_OFFS, r);
    check_val(r, 8'hff, "mask general");
    host.write_reg(4'h0, rffe_expander_pkg::VALUE_OFFS, 8'($random(seed)) | 8'h81);
    settle();
    check_pins(8'h00, 8'hff, 8'h00, 8'hff);
    val = 8'h00;
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      h = 8'($random(seed));
      m = 8'($random(seed));
      v = 8'($random(seed));
      host.general_config(4'h9, d, e, h, m, v);
      val = (val & m) | (v & ~m);
      settle();
      check_pins(val, ~val | h, e & d, e & ~d);
    end
    host.read_reg(4'h9, rffe_expander_pkg::PULL_DIR_OFFS, r);
    check_val(r, d, "pull direction");
    host.read_reg(4'h9, rffe_expander_pkg::STATUS_OFFS, r);
    check_val(r, 8'h93, "status general");
    @(posedge ref_clk_i);
    supply <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    supply <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    check_pins(8'h00, 8'h00, 8'h00, 8'hff);
    host.read_reg(4'h9, rffe_expander_pkg::MASK_OFFS, r);
    check_val(r, 8'hff, "mask after supply reset");
    $display("test general mode done");
    final_report();
  end
endmodule : rffe_output_expander_test
`default_nettype wire
